// ---- bench/test_trace_stamp_arbiter.sv ----
// Self-checking bench for the stamp arbiter against a trace sink model
`timescale 1ns/100ps
`include "trace_ts_consts.svh"
module test_trace_stamp_arbiter;
  typedef struct {
    trace_ts_pkg::pkt_kind_t kind;
    logic [2:0] fm;
    logic [37:0] data;
    logic [37:0] mask;
  } note_t;
  localparam logic [37:0] M32 = 38'h00ffffffff;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic local_rst_n = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic reg_unpriv = 1'b0;
  logic [31:0] reg_rdata;
  logic [63:0] cnt = 64'h0;
  logic clock_change_pin = 1'b0;
  logic full_stamp_req = 1'b0;
  logic [1:0] tap = 2'h0;
  logic hw_valid = 1'b0;
  logic [31:0] hw_data = 32'h0;
  logic hw_ready;
  logic local_valid = 1'b0;
  logic [27:0] local_data = 28'h0;
  logic local_ready;
  trace_ts_pkg::trace_pkt_t trace_pkt;
  trace_ts_pkg::trace_pkt_t got_pkt;
  logic trace_valid;
  logic trace_ready;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic got;
  logic rd_pend = 1'b0;
  logic [31:0] d;
  logic [1:0] fl [5] = '{2'b01, 2'b00, 2'b01, 2'b10, 2'b01};
  integer seed = 32'hd1101d87;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [31:0] rq[$];
  note_t pq[$];

  always #2 clock = ~clock;

  trace_stamp_arbiter #(.RATE3_CYCLES(16), .SYNC1_CYCLES(20), .SYNC2_CYCLES(40),
    .SYNC3_CYCLES(80)) i_trace_stamp_arbiter (.clock(clock), .rst_n(rst_n),
    .local_rst_n(local_rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_unpriv(reg_unpriv),
    .reg_rdata(reg_rdata), .stamp_count(cnt), .clock_change_pin(clock_change_pin),
    .full_stamp_req(full_stamp_req), .sync_rate_tap_field(tap), .hw_valid(hw_valid),
    .hw_port(8'h05), .hw_data(hw_data), .hw_ready(hw_ready), .local_valid(local_valid),
    .local_data(local_data), .local_ready(local_ready), .trace_pkt(trace_pkt),
    .trace_valid(trace_valid), .trace_ready(trace_ready));

  trace_sink_model i_trace_sink_model (.clock(clock), .rst_n(rst_n), .trace_pkt(trace_pkt),
    .trace_valid(trace_valid), .trace_ready(trace_ready), .stall(stall), .slow(slow),
    .got(got), .got_pkt(got_pkt));

  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task automatic miss(input logic [63:0] e, input logic [63:0] g);
    failures++;
    $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
  endtask : miss

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) miss(e, g);
  endtask : cmp_word

  task automatic cmp_pkt(input trace_ts_pkg::trace_pkt_t g);
    note_t e;
    n_compared++;
    if (pq.size() == 0) begin
      miss(64'h0, g);
      return;
    end
    e = pq.pop_front();
    if (!((g.kind === e.kind) && (!e.fm[2] || g.flags === e.fm[1:0])
        && ((g.data & e.mask) === (e.data & e.mask))))
      miss({e.kind, e.fm, e.data}, {g.kind, 1'b0, g.flags, g.data});
  endtask : cmp_pkt

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic note(input trace_ts_pkg::pkt_kind_t k, input logic [2:0] f,
      input logic [37:0] v, input logic [37:0] m);
    pq.push_back('{k, f, v, m});
  endtask : note

  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic u);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_unpriv <= u;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clock);
    reg_addr <= a;
    reg_unpriv <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
  endtask : rd

  task automatic send(input logic loc, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clock);
    hw_valid <= !loc;
    local_valid <= loc;
    hw_data <= v;
    local_data <= v[27:0];
    do begin
      @(posedge clock);
      n++;
    end while (!(loc ? local_ready : hw_ready) && n < 100);
    hw_valid <= 1'b0;
    local_valid <= 1'b0;
  endtask : send

  task automatic drain(input int settle);
    int n;
    n = 0;
    while (pq.size() != 0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    if (pq.size() != 0) miss(64'h0, pq.size());
    repeat (settle) @(posedge clock);
  endtask : drain

  // Scoreboard: read data one cycle after the strobe, packets as the sink takes them
  always @(posedge clock) begin
    if (rd_pend && rq.size() != 0) cmp_word(rq.pop_front(), reg_rdata);
    rd_pend <= reg_read;
    if (got) cmp_pkt(got_pkt);
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd(`TS_TER_BASE, `TS_REG_RESET);
    rd(`TS_TPR_ADDR, `TS_REG_RESET);
    rd(`TS_TCR_ADDR, `TS_REG_RESET);
    rd(32'he0000f00, 32'h0);
    wr(`TS_TER_BASE, 32'h1, 1'b0);
    wr(`TS_STIM_BASE, 32'h1234, 1'b0);
    rd(`TS_STIM_BASE, 32'h0);
    drain(12);
    $display("test reset_and_disable done");
    wr(`TS_TCR_ADDR, 32'h1, 1'b0);
    slow <= 1'b1;
    d = $random(seed);
    note(trace_ts_pkg::PK_STIM, 3'b0, {6'h0, d}, M32);
    wr(`TS_TER_BASE + 32'hc, 32'h80000000, 1'b0);
    wr(`TS_STIM_BASE + 32'h1fc, d, 1'b0);
    drain(12);
    // Held output, then overflow, stimulus, hw and local queue up
    slow <= 1'b0;
    stall <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      d = $random(seed);
      if (k == 1) note(trace_ts_pkg::PK_OVF, 3'b0, 38'h0, 38'h0);
      if (k < 2) note(trace_ts_pkg::PK_STIM, 3'b0, {6'h0, d}, M32);
      wr(`TS_STIM_BASE, d, 1'b0);
      repeat (3) @(posedge clock);
    end
    rd(`TS_STIM_BASE, 32'h0);
    d = $random(seed);
    note(trace_ts_pkg::PK_HW, 3'b0, {6'h0, d}, M32);
    send(1'b0, d);
    d = $random(seed);
    note(trace_ts_pkg::PK_LOCAL, 3'b0, {10'h0, d[27:0]}, 38'hfffffff);
    send(1'b1, d);
    stall <= 1'b0;
    drain(12);
    $display("test priority_and_overflow done");
    wr(`TS_TCR_ADDR, 32'h401, 1'b0);
    cnt <= {$random(seed), $random(seed)};
    for (int i = 0; i < 5; i++) begin
      if (i == 2) full_stamp_req <= 1'b1;
      if (i == 3) clock_change_pin <= 1'b1;
      if (i == 4) cnt[63:26] <= ~cnt[63:26];
      @(posedge clock);
      full_stamp_req <= 1'b0;
      repeat (6) @(posedge clock);
      d = $random(seed);
      note(trace_ts_pkg::PK_STIM, 3'b0, {6'h0, d}, M32);
      note(trace_ts_pkg::PK_GLOW, {1'b1, fl[i]}, {12'h0, cnt[25:0]},
        (i == 1) ? 38'h0 : 38'h3ffffff);
      if (i != 1) note(trace_ts_pkg::PK_GHIGH, 3'b0, cnt[63:26], {38{1'b1}});
      wr(`TS_STIM_BASE, d, 1'b0);
      drain(12);
    end
    $display("test global_stamps done");
    local_rst_n <= 1'b0;
    @(posedge clock);
    local_rst_n <= 1'b1;
    wr(`TS_TCR_ADDR, 32'h0, 1'b1);
    rd(`TS_TCR_ADDR, 32'h401);
    // Masked unprivileged enable write leaves port 0 enabled
    wr(`TS_TPR_ADDR, 32'h1, 1'b0);
    wr(`TS_TER_BASE, 32'h0, 1'b1);
    rd(`TS_TER_BASE, 32'h1);
    wr(`TS_TCR_ADDR, 32'h5, 1'b0);
    for (int t = 1; t < 4; t++) begin
      note(trace_ts_pkg::PK_SYNC, 3'b0, 38'h0, 38'h0);
      tap <= t[1:0];
      drain(0);
      tap <= 2'h0;
      repeat (100) @(posedge clock);
    end
    $display("test local_reset_and_sync done");
    give_verdict();
  end
endmodule : test_trace_stamp_arbiter

// ---- bench/trace_sink_model.sv ----
// Trace sink model that accepts the merged stream, with stall and pacing
`timescale 1ns/100ps
module trace_sink_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire trace_ts_pkg::trace_pkt_t trace_pkt,
  input wire logic trace_valid,
  output logic trace_ready,
  input wire logic stall,
  input wire logic slow,
  output logic got,
  output trace_ts_pkg::trace_pkt_t got_pkt
);
  // ----------------------------------------
  // Acceptance
  // ----------------------------------------
  // Ready pacing, every other cycle when slow
  always_ff @(posedge clock) begin
    if (!rst_n) trace_ready <= 1'b0;
    else trace_ready <= !stall && (!slow || !trace_ready);
  end
  // Report each accepted packet one cycle later
  always_ff @(posedge clock) begin
    got <= rst_n && trace_valid && trace_ready;
    got_pkt <= trace_pkt;
  end
endmodule : trace_sink_model

// ---- logic/trace_src_slot.sv ----
// One-entry packet slot for a trace source, with a lateness flag
`timescale 1ns/100ps
module trace_src_slot #(
  parameter int unsigned LATE_AFTER = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic load,
  input wire trace_ts_pkg::trace_pkt_t load_pkt,
  input wire logic take,
  output logic vacant,
  output trace_ts_pkg::trace_pkt_t held,
  output logic delayed
);

  logic [1:0] age;

  // Hold one packet and age it while it waits
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vacant <= 1'h1;
      age <= 2'h0;
      held <= '0;
    end else if (load) begin
      vacant <= 1'h0;
      held <= load_pkt;
      age <= 2'h0;
    end else if (take) begin
      vacant <= 1'h1;
    end else if (!vacant && age != 2'h3) begin
      age <= age + 2'h1;
    end
  end

  // Late once it has waited LATE_AFTER cycles or more
  assign delayed = (age >= 2'(LATE_AFTER));

endmodule : trace_src_slot

// ---- logic/trace_stamp_arbiter.sv ----
// Global stamps, sync packets and priority merge of the trace stream
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "trace_ts_consts.svh"
module trace_stamp_arbiter #(
  parameter int unsigned RATE3_CYCLES = `TS_RATE3_NS / `TS_PERIOD_NS,
  parameter int unsigned SYNC1_CYCLES = `TS_SYNC1_NS / `TS_PERIOD_NS,
  parameter int unsigned SYNC2_CYCLES = `TS_SYNC2_NS / `TS_PERIOD_NS,
  parameter int unsigned SYNC3_CYCLES = `TS_SYNC3_NS / `TS_PERIOD_NS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic local_rst_n,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_unpriv,
  output logic [31:0] reg_rdata,
  input wire logic [63:0] stamp_count,
  input wire logic clock_change_pin,
  input wire logic full_stamp_req,
  input wire logic [1:0] sync_rate_tap_field,
  input wire logic hw_valid,
  input wire logic [7:0] hw_port,
  input wire logic [31:0] hw_data,
  output logic hw_ready,
  input wire logic local_valid,
  input wire logic [27:0] local_data,
  output logic local_ready,
  output trace_ts_pkg::trace_pkt_t trace_pkt,
  output logic trace_valid,
  input wire logic trace_ready
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0] tcr;
  logic [31:0] tpr;
  logic [31:0] ter [8];
  logic run_n;
  logic stim_hit, ter_hit, trace_on, port_on, priv_ok, stim_wr;
  logic [7:0] port;
  logic [2:0] ter_idx;
  logic [1:0] rate;
  logic [1:0] prev_rate;
  logic rate_on, rate_edge;
  logic [2:0] cc_sync;
  logic cc_level, cc_pulse;
  logic ovf_pend, sync_pend, full_need, cc_need, req_pend, high_has_req;
  logic glow_pend, ghigh_pend, stamp_due, gen, ev, full_now, still_high;
  logic [31:0] stamp_cnt, stamp_limit, sync_cnt, sync_limit;
  logic [25:0] stamp_low, last_low;
  logic [37:0] stamp_high, last_high, ghigh_data;
  trace_ts_pkg::trace_pkt_t glow_pkt, pick_pkt;
  trace_ts_pkg::trace_pkt_t stim_pkt, hw_pkt, local_pkt;
  trace_ts_pkg::trace_pkt_t stim_held, hw_held, local_held;
  trace_ts_pkg::pkt_kind_t pick;
  logic stim_vacant, stim_delayed, hw_delayed, can_load;
  logic take_sync, take_ovf, take_stim, take_hw, take_local;
  logic take_glow, take_high;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign run_n = rst_n && local_rst_n;
  assign stim_hit = reg_addr >= `TS_STIM_BASE && reg_addr <= `TS_STIM_LAST
                    && reg_addr[1:0] == 2'h0;
  assign ter_hit = reg_addr >= `TS_TER_BASE && reg_addr <= `TS_TER_LAST
                   && reg_addr[1:0] == 2'h0;
  assign port = reg_addr[9:2];
  assign ter_idx = reg_addr[4:2];
  assign trace_on = tcr[`TS_TCR_ENA_BIT];
  assign port_on = ter[port[7:5]][port[4:0]];
  assign priv_ok = !reg_unpriv || !tpr[port[7:3]];
  assign stim_wr = reg_write && stim_hit && trace_on && port_on && priv_ok;
  assign rate = tcr[`TS_TCR_RATE_LSB +: 2];
  assign rate_on = rate != 2'h0;

  // Control registers, cleared by power-on reset only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tcr <= `TS_REG_RESET;
      tpr <= `TS_REG_RESET;
      for (int i = 0; i < 8; i++) begin
        ter[i] <= `TS_REG_RESET;
      end
    end else if (reg_write && !reg_unpriv && reg_addr == `TS_TCR_ADDR) begin
      tcr <= reg_wdata;
    end else if (reg_write && !reg_unpriv && reg_addr == `TS_TPR_ADDR) begin
      tpr <= reg_wdata;
    end else if (reg_write && ter_hit) begin
      for (int j = 0; j < 4; j++) begin
        if (!reg_unpriv || !tpr[{ter_idx, 2'(j)}]) begin
          ter[ter_idx][j*8 +: 8] <= reg_wdata[j*8 +: 8];
        end
      end
    end
  end

  // Read data for one cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_read) begin
      if (stim_hit) begin
        reg_rdata <= {31'h0, trace_on && port_on && stim_vacant};
      end else if (ter_hit) begin
        reg_rdata <= ter[ter_idx];
      end else if (reg_addr == `TS_TPR_ADDR) begin
        reg_rdata <= tpr;
      end else if (reg_addr == `TS_TCR_ADDR) begin
        reg_rdata <= tcr;
      end else begin
        reg_rdata <= 32'h0;
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // ----------------------------------------
  // Source slots
  // ----------------------------------------
  assign stim_pkt = '{kind: trace_ts_pkg::PK_STIM, port: port, bytes: `TS_WORD_BYTES,
                      flags: 2'h0, data: {6'h0, reg_wdata}};
  assign hw_pkt = '{kind: trace_ts_pkg::PK_HW, port: hw_port, bytes: `TS_WORD_BYTES,
                    flags: 2'h0, data: {6'h0, hw_data}};
  assign local_pkt = '{kind: trace_ts_pkg::PK_LOCAL, port: 8'h0, bytes: `TS_WORD_BYTES,
                       flags: 2'h0, data: {10'h0, local_data}};

  trace_src_slot #(.LATE_AFTER(1)) u_stim_slot (
    .clock(clock),
    .rst_n(run_n),
    .load(stim_wr && (stim_vacant || take_stim)),
    .load_pkt(stim_pkt),
    .take(take_stim),
    .vacant(stim_vacant),
    .held(stim_held),
    .delayed(stim_delayed)
  );

  trace_src_slot #(.LATE_AFTER(1)) u_hw_slot (
    .clock(clock),
    .rst_n(run_n),
    .load(hw_valid && hw_ready),
    .load_pkt(hw_pkt),
    .take(take_hw),
    .vacant(hw_ready),
    .held(hw_held),
    .delayed(hw_delayed)
  );

  trace_src_slot #(.LATE_AFTER(1)) u_local_slot (
    .clock(clock),
    .rst_n(run_n),
    .load(local_valid && local_ready),
    .load_pkt(local_pkt),
    .take(take_local),
    .vacant(local_ready),
    .held(local_held),
    .delayed()
  );

  // Overflow raised by a write into a busy buffer, set beats clear
  always_ff @(posedge clock) begin
    if (!run_n) begin
      ovf_pend <= 1'h0;
    end else if (stim_wr && !stim_vacant && !take_stim) begin
      ovf_pend <= 1'h1;
    end else if (take_ovf) begin
      ovf_pend <= 1'h0;
    end
  end

  // ----------------------------------------
  // Clock change pin and full-stamp causes
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cc_sync <= 3'h0;
      cc_level <= 1'h0;
    end else begin
      cc_sync <= {cc_sync[1:0], clock_change_pin};
      if (cc_sync[1] == cc_sync[2]) begin
        cc_level <= cc_sync[2];
      end
    end
  end
  assign cc_pulse = cc_sync[1] && cc_sync[2] && !cc_level;

  // Causes that force the next stamp to be full
  always_ff @(posedge clock) begin
    if (!run_n) begin
      prev_rate <= 2'h0;
      full_need <= 1'h0;
      cc_need <= 1'h0;
      req_pend <= 1'h0;
    end else begin
      prev_rate <= rate;
      full_need <= (full_need && !gen) || rate_edge || cc_pulse;
      cc_need <= (cc_need && !gen) || cc_pulse;
      req_pend <= (req_pend && !(take_high && high_has_req)) || full_stamp_req;
    end
  end
  assign rate_edge = prev_rate == 2'h0 && rate_on;

  // ----------------------------------------
  // Global stamp generation
  // ----------------------------------------
  always_comb begin
    case (rate)
      2'h2: stamp_limit = 32'(`TS_RATE2_CYCLES);
      2'h3: stamp_limit = 32'(RATE3_CYCLES);
      default: stamp_limit = 32'h0;
    endcase
  end

  // Rate timer marks a stamp as due
  always_ff @(posedge clock) begin
    if (!run_n || !rate_on || gen) begin
      stamp_cnt <= 32'h0;
      stamp_due <= 1'h0;
    end else if (stamp_cnt >= stamp_limit) begin
      stamp_due <= 1'h1;
    end else begin
      stamp_cnt <= stamp_cnt + 32'h1;
    end
  end

  assign ev = (take_stim && !stim_delayed) || (take_hw && !hw_delayed);
  assign gen = stamp_due && rate_on && ev;
  assign stamp_low = stamp_count[25:0];
  assign stamp_high = stamp_count[63:26];
  assign still_high = ghigh_pend && !take_high;
  assign full_now = full_need || req_pend || stamp_high != last_high;

  // Bytes needed for the changed low bits, seven per byte
  function automatic logic [2:0] low_bytes(input logic [25:0] diff);
    if (diff[25:21] != 5'h0) begin
      low_bytes = 3'h4;
    end else if (diff[20:14] != 7'h0) begin
      low_bytes = 3'h3;
    end else if (diff[13:7] != 7'h0) begin
      low_bytes = 3'h2;
    end else begin
      low_bytes = 3'h1;
    end
  endfunction : low_bytes

  // Build low and high stamp packets
  always_ff @(posedge clock) begin
    if (!run_n) begin
      glow_pend <= 1'h0;
      ghigh_pend <= 1'h0;
      high_has_req <= 1'h0;
      glow_pkt <= '0;
      ghigh_data <= 38'h0;
      last_high <= 38'h0;
      last_low <= 26'h0;
    end else if (!rate_on) begin
      glow_pend <= 1'h0;
      ghigh_pend <= 1'h0;
    end else begin
      if (take_glow) begin
        glow_pend <= 1'h0;
      end
      if (take_high) begin
        ghigh_pend <= 1'h0;
        high_has_req <= 1'h0;
      end
      if (gen) begin
        glow_pend <= 1'h1;
        last_low <= stamp_low;
        glow_pkt.kind <= trace_ts_pkg::PK_GLOW;
        glow_pkt.port <= 8'h0;
        glow_pkt.data <= {12'h0, stamp_low};
        glow_pkt.flags[1] <= full_now && cc_need && !still_high;
        glow_pkt.flags[0] <= (full_now && !cc_need) || still_high;
        if (full_now || still_high) begin
          glow_pkt.bytes <= `TS_WORD_BYTES;
          ghigh_pend <= 1'h1;
          ghigh_data <= stamp_high;
          high_has_req <= (high_has_req && still_high) || req_pend;
        end else begin
          glow_pkt.bytes <= low_bytes(stamp_low ^ last_low);
        end
        if (full_now) begin
          last_high <= stamp_high;
        end
      end
    end
  end

  // ----------------------------------------
  // Sync packet timer
  // ----------------------------------------
  always_comb begin
    case (sync_rate_tap_field)
      2'h1: sync_limit = 32'(SYNC1_CYCLES);
      2'h2: sync_limit = 32'(SYNC2_CYCLES);
      2'h3: sync_limit = 32'(SYNC3_CYCLES);
      default: sync_limit = 32'h0;
    endcase
  end

  // Periodic sync request while enabled
  always_ff @(posedge clock) begin
    if (!run_n) begin
      sync_cnt <= 32'h0;
      sync_pend <= 1'h0;
    end else begin
      if (take_sync) begin
        sync_pend <= 1'h0;
      end
      if (!tcr[`TS_TCR_SYNC_BIT] || sync_limit == 32'h0) begin
        sync_cnt <= 32'h0;
      end else if (sync_cnt >= sync_limit - 32'h1) begin
        sync_cnt <= 32'h0;
        sync_pend <= 1'h1;
      end else begin
        sync_cnt <= sync_cnt + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // Arbitration and output register
  // ----------------------------------------
  assign can_load = !trace_valid || trace_ready;

  // Fixed priority pick, stamps last
  always_comb begin
    pick = trace_ts_pkg::PK_IDLE;
    if (can_load && trace_on) begin
      if (sync_pend) begin
        pick = trace_ts_pkg::PK_SYNC;
      end else if (ovf_pend) begin
        pick = trace_ts_pkg::PK_OVF;
      end else if (!stim_vacant) begin
        pick = trace_ts_pkg::PK_STIM;
      end else if (!hw_ready) begin
        pick = trace_ts_pkg::PK_HW;
      end else if (!local_ready) begin
        pick = trace_ts_pkg::PK_LOCAL;
      end else if (glow_pend) begin
        pick = trace_ts_pkg::PK_GLOW;
      end else if (ghigh_pend) begin
        pick = trace_ts_pkg::PK_GHIGH;
      end
    end
  end

  // Packet of the chosen source
  always_comb begin
    pick_pkt = '0;
    pick_pkt.kind = pick;
    case (pick)
      trace_ts_pkg::PK_SYNC: pick_pkt.bytes = `TS_SYNC_BYTES;
      trace_ts_pkg::PK_OVF: pick_pkt.bytes = `TS_OVF_BYTES;
      trace_ts_pkg::PK_STIM: pick_pkt = stim_held;
      trace_ts_pkg::PK_HW: pick_pkt = hw_held;
      trace_ts_pkg::PK_LOCAL: pick_pkt = local_held;
      trace_ts_pkg::PK_GLOW: pick_pkt = glow_pkt;
      trace_ts_pkg::PK_GHIGH: begin
        pick_pkt.bytes = 3'h5;
        pick_pkt.data = ghigh_data;
      end
      default: pick_pkt = '0;
    endcase
  end

  assign take_sync = pick == trace_ts_pkg::PK_SYNC;
  assign take_ovf = pick == trace_ts_pkg::PK_OVF;
  assign take_stim = pick == trace_ts_pkg::PK_STIM;
  assign take_hw = pick == trace_ts_pkg::PK_HW;
  assign take_local = pick == trace_ts_pkg::PK_LOCAL;
  assign take_glow = pick == trace_ts_pkg::PK_GLOW;
  assign take_high = pick == trace_ts_pkg::PK_GHIGH;

  // Single merged output stream
  always_ff @(posedge clock) begin
    if (!run_n) begin
      trace_valid <= 1'h0;
      trace_pkt <= '0;
    end else if (can_load) begin
      trace_valid <= pick != trace_ts_pkg::PK_IDLE;
      trace_pkt <= pick_pkt;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!run_n);

  a_low_before_high: assert property (take_high |-> !glow_pend)
    else $error("high stamp sent before low stamp");
  a_stamps_wait_queues: assert property ((take_glow || take_high || take_local)
    |-> stim_vacant && hw_ready && !ovf_pend)
    else $error("stamp sent while a source queue holds data");
  a_sync_first: assert property (sync_pend && can_load && trace_on
    |=> trace_valid && trace_pkt.kind == trace_ts_pkg::PK_SYNC)
    else $error("pending sync did not win arbitration");
  a_enable_gates: assert property (!trace_on && can_load |=> !trace_valid)
    else $error("output while trace disabled");
  a_rate_off: assert property (!rate_on |=> !glow_pend && !ghigh_pend)
    else $error("global stamp pending with rate zero");
  a_wrap_on_repeat: assert property (gen && still_high
    |=> glow_pkt.flags[0] && ghigh_pend)
    else $error("repeat stamp without wrap");
  a_request_holds: assert property (req_pend && !take_high |=> req_pend)
    else $error("full stamp request dropped");
  a_overflow_raised: assert property (stim_wr && !stim_vacant && !take_stim
    |=> ovf_pend)
    else $error("write to full buffer without overflow");
  a_high_latest: assert property (gen && full_now
    |=> ghigh_data == $past(stamp_count[63:26]))
    else $error("high stamp not from latest low stamp");
  a_gen_after_event: assert property (glow_pend && !$past(glow_pend)
    |-> $past(ev))
    else $error("stamp without non-delayed packet");

endmodule : trace_stamp_arbiter

// ---- pkg/trace_ts_consts.svh ----
// Offsets, field positions, reset values and timing for the stamp arbiter
`ifndef TRACE_TS_CONSTS_SVH
`define TRACE_TS_CONSTS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define TS_STIM_BASE 32'he0000000
`define TS_STIM_LAST 32'he00003fc
`define TS_TER_BASE 32'he0000e00
`define TS_TER_LAST 32'he0000e1c
`define TS_TPR_ADDR 32'he0000e40
`define TS_TCR_ADDR 32'he0000e80
`define TS_REG_RESET 32'h00000000

// ----------------------------------------
// Control fields
// ----------------------------------------
`define TS_TCR_ENA_BIT 0
`define TS_TCR_SYNC_BIT 2
`define TS_TCR_RATE_LSB 10

// ----------------------------------------
// Stamp layout and packet sizes
// ----------------------------------------
`define TS_LOW_BITS 26
`define TS_STAMP_BITS 64
`define TS_WORD_BYTES 3'h4
`define TS_OVF_BYTES 3'h1
`define TS_SYNC_BYTES 3'h6

// ----------------------------------------
// Timing, clock period 4 ns
// ----------------------------------------
`define TS_PERIOD_NS 4
`define TS_RATE2_NS 512
`define TS_RATE2_CYCLES (`TS_RATE2_NS / `TS_PERIOD_NS)
`define TS_RATE3_NS 32768
`define TS_SYNC1_NS 65536
`define TS_SYNC2_NS 262144
`define TS_SYNC3_NS 1048576

`endif

// ---- pkg/trace_ts_pkg.sv ----
// Types shared by the stamp arbiter and its source slots
package trace_ts_pkg;

  typedef enum logic [2:0] {
    PK_IDLE  = 3'b000,
    PK_SYNC  = 3'b001,
    PK_OVF   = 3'b010,
    PK_STIM  = 3'b011,
    PK_HW    = 3'b100,
    PK_LOCAL = 3'b101,
    PK_GLOW  = 3'b110,
    PK_GHIGH = 3'b111
  } pkt_kind_t;

  // flags[1] clock change, flags[0] wrap
  typedef struct packed {
    pkt_kind_t kind;
    logic [7:0] port;
    logic [2:0] bytes;
    logic [1:0] flags;
    logic [37:0] data;
  } trace_pkt_t;

endpackage : trace_ts_pkg
